// file: rtl/dbam_monitor.sv
// Drop bus alarm monitor: AIS, parity, loss of clock, H4 multiframe and latched alarms
//
// Our own choice: the plain strobed port.
`include "dbam_defines.svh"

module dbam_monitor #(
  parameter int NUM_CH     = 8,
  parameter int LOC_CYCLES = `DBAM_LOC_CYCLES,
  parameter int LOM_CYCLES = `DBAM_LOM_TIME_NS / `DBAM_CLK_PERIOD_NS
) (
  input  wire logic                          core_clk_i,
  input  wire logic                          nrst_i,
  input  wire logic                          drop_bus_clock_i,
  input  wire logic [7:0]                    drop_data_i,
  input  wire logic                          drop_parity_i,
  input  wire dbam_pkg::dbam_seg_t           drop_seg_i,
  input  wire logic                          drop_h1_i,
  input  wire logic                          drop_h2_i,
  input  wire logic                          drop_e1_i,
  input  wire logic                          drop_h4_i,
  input  wire logic [2*NUM_CH-1:0]           chan_seg_i,
  input  wire logic [7:0]                    addr_i,
  input  wire logic [7:0]                    wr_data_i,
  input  wire logic                          wr_stb_i,
  input  wire logic                          rd_stb_i,
  output logic      [7:0]                    rd_data_o,
  output logic      [NUM_CH-1:0]             channel_pointer_lost_o
);
  import dbam_pkg::*;

  localparam int LOCW = $clog2(LOC_CYCLES + 1);
  localparam int LOMW = $clog2(LOM_CYCLES + 1);
  localparam logic [LOCW-1:0] LOC_LAST = LOCW'(LOC_CYCLES - 1);
  localparam logic [LOMW-1:0] LOM_LAST = LOMW'(LOM_CYCLES - 1);
  localparam logic [2:0]      MF_GOOD  = 3'(`DBAM_MF_GOOD_FRAMES);

  typedef struct packed {
    logic                   clk_s1;
    logic                   clk_s2;
    logic                   clk_prev;
    logic [14:0]            bus_s1;
    logic [14:0]            bus_s2;
    logic [7:0]             cfg;
    logic [LOCW-1:0]        loc_cnt;
    logic                   loc;
    logic                   par;
    logic [2:0]             h1_ff;
    logic [2:0]             ptr_ais;
    logic [2:0]             e1_ais;
    logic [2:0]             ais;
    logic [2:0]             oom;
    logic [2:0]             lom;
    logic [2:0][1:0]        mf_prev;
    logic [2:0][2:0]        mf_run;
    logic [2:0][LOMW-1:0]   lom_cnt;
    logic [4:0]             live_prev;
    logic [4:0]             latched;
    logic [7:0]             rdata;
    logic [NUM_CH-1:0]      lop;
  } dbam_state_t;

  dbam_state_t q_reg;
  dbam_state_t q_next;

  logic       clk_edge;
  logic       clk_rise;
  logic [7:0] bdata;
  logic       bpar;
  dbam_seg_t  bseg;
  logic       bh1;
  logic       bh2;
  logic       be1;
  logic       bh4;
  logic       par_err;
  logic [4:0] live_word;
  logic [4:0] trans;
  dbam_edge_t edge_mode;
  logic       rd_latch;

  assign clk_edge  = q_reg.clk_s2 != q_reg.clk_prev;
  assign clk_rise  = q_reg.clk_s2 & ~q_reg.clk_prev;
  assign bdata     = q_reg.bus_s2[7:0];
  assign bpar      = q_reg.bus_s2[8];
  assign bseg      = q_reg.bus_s2[10:9];
  assign bh1       = q_reg.bus_s2[11];
  assign bh2       = q_reg.bus_s2[12];
  assign be1       = q_reg.bus_s2[13];
  assign bh4       = q_reg.bus_s2[14];
  assign par_err   = (^{bdata, bpar}) != q_reg.cfg[`DBAM_CFG_ODD_PAR];
  assign live_word = {q_reg.ais, q_reg.par, q_reg.loc};
  assign edge_mode = dbam_edge_t'(q_reg.cfg[`DBAM_CFG_EDGE_HI:`DBAM_CFG_EDGE_LO]);
  assign rd_latch  = rd_stb_i && (addr_i == `DBAM_ADDR_LATCH);
  assign trans     = ((edge_mode == DBAM_EDGE_RISE || edge_mode == DBAM_EDGE_BOTH) ?
                      (live_word & ~q_reg.live_prev) : 5'h00) |
                     ((edge_mode == DBAM_EDGE_FALL || edge_mode == DBAM_EDGE_BOTH) ?
                      (~live_word & q_reg.live_prev) : 5'h00);

  always_comb begin
    logic       hit;
    logic       match;
    logic [2:0] run;
    dbam_seg_t  cs;
    hit   = 1'b0;
    match = 1'b0;
    run   = 3'h0;
    cs    = 2'h0;
    q_next = q_reg;
    q_next.clk_s1   = drop_bus_clock_i;
    q_next.clk_s2   = q_reg.clk_s1;
    q_next.clk_prev = q_reg.clk_s2;
    q_next.bus_s1   = {drop_h4_i, drop_e1_i, drop_h2_i, drop_h1_i, drop_seg_i,
                       drop_parity_i, drop_data_i};
    q_next.bus_s2   = q_reg.bus_s1;

    // Core clock counts time since the last drop clock transition
    if (clk_edge) begin
      q_next.loc_cnt = '0;
      q_next.loc     = 1'b0;
    end else if (q_reg.loc_cnt == LOC_LAST) begin
      q_next.loc = 1'b1;
    end else begin
      q_next.loc_cnt = q_reg.loc_cnt + 1'b1;
    end

    if (clk_rise) begin
      q_next.par = par_err;
    end

    for (int s = 0; s < 3; s++) begin
      hit = clk_rise && (bseg == dbam_seg_t'(s + 1));
      if (hit && bh1) begin
        q_next.h1_ff[s] = bdata == `DBAM_AIS_BYTE;
      end
      if (hit && bh2) begin
        q_next.ptr_ais[s] = q_reg.h1_ff[s] && (bdata == `DBAM_AIS_BYTE);
      end
      if (hit && be1) begin
        q_next.e1_ais[s] = bdata == `DBAM_AIS_BYTE;
      end
      q_next.ais[s] = (q_reg.cfg[`DBAM_CFG_PTR_EN] & q_reg.ptr_ais[s]) |
                      (q_reg.cfg[`DBAM_CFG_E1_SEL] & q_reg.e1_ais[s]);
      if (s != 0 && q_reg.cfg[`DBAM_CFG_VC4]) begin
        q_next.ais[s] = 1'b0;
      end

      // H4 multiframe tracking per segment
      if (q_reg.cfg[`DBAM_CFG_V1SEL]) begin
        q_next.oom[s]     = 1'b0;
        q_next.lom[s]     = 1'b0;
        q_next.mf_run[s]  = 3'h0;
        q_next.lom_cnt[s] = '0;
      end else begin
        if (q_reg.oom[s] && !q_reg.lom[s]) begin
          if (q_reg.lom_cnt[s] == LOM_LAST) begin
            q_next.lom[s] = 1'b1;
          end else begin
            q_next.lom_cnt[s] = q_reg.lom_cnt[s] + 1'b1;
          end
        end
        if (hit && bh4) begin
          match = bdata[1:0] == q_reg.mf_prev[s] + 2'h1;
          q_next.mf_prev[s] = bdata[1:0];
          if (!q_reg.oom[s]) begin
            if (!match) begin
              q_next.oom[s]    = 1'b1;
              q_next.mf_run[s] = 3'h1;
            end
          end else begin
            run = match ? q_reg.mf_run[s] + 3'h1 : 3'h1;
            q_next.mf_run[s] = run;
            if (run == MF_GOOD) begin
              q_next.oom[s]     = 1'b0;
              q_next.lom[s]     = 1'b0;
              q_next.lom_cnt[s] = '0;
              q_next.mf_run[s]  = 3'h0;
            end
          end
        end
      end
    end

    for (int c = 0; c < NUM_CH; c++) begin
      cs = chan_seg_i[2*c +: 2];
      q_next.lop[c] = (cs != 2'h0) && q_reg.lom[cs - 2'h1];
    end

    // Register bus
    q_next.live_prev = live_word;
    q_next.rdata     = 8'h00;
    if (rd_stb_i) begin
      unique case (addr_i)
        `DBAM_ADDR_CFG:   q_next.rdata = q_reg.cfg;
        `DBAM_ADDR_LIVE:  q_next.rdata = {3'h0, live_word};
        `DBAM_ADDR_MF:    q_next.rdata = {2'h0, q_reg.oom, q_reg.lom};
        `DBAM_ADDR_LATCH: q_next.rdata = {3'h0, q_reg.latched};
        default:          q_next.rdata = 8'h00;
      endcase
    end
    q_next.latched = (rd_latch ? 5'h00 : q_reg.latched) | trans;
    if (wr_stb_i && addr_i == `DBAM_ADDR_CFG) begin
      q_next.cfg = wr_data_i & `DBAM_CFG_MASK;
    end
  end

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      q_reg     <= '0;
      q_reg.cfg <= `DBAM_CFG_RESET;
    end else begin
      q_reg <= q_next;
    end
  end

  assign rd_data_o              = q_reg.rdata;
  assign channel_pointer_lost_o = q_reg.lop;

  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!nrst_i);

  property p_seg3_ais;
    q_reg.cfg[`DBAM_CFG_PTR_EN] && q_reg.ptr_ais[2] && !q_reg.cfg[`DBAM_CFG_VC4]
      |=> q_reg.ais[2];
  endproperty
  a_seg3_ais: assert property (p_seg3_ais) else $error("seg3 AIS missed");

  property p_src_off;
    !q_reg.cfg[`DBAM_CFG_PTR_EN] && !q_reg.cfg[`DBAM_CFG_E1_SEL] |=> q_reg.ais == 3'h0;
  endproperty
  a_src_off: assert property (p_src_off) else $error("AIS with no source");

  property p_vc4_mask;
    q_reg.cfg[`DBAM_CFG_VC4] |=> q_reg.ais[2:1] == 2'h0;
  endproperty
  a_vc4_mask: assert property (p_vc4_mask) else $error("seg2/3 AIS in VC-4");

  property p_seg1_e1;
    q_reg.cfg[`DBAM_CFG_E1_SEL] && q_reg.e1_ais[0] |=> q_reg.ais[0];
  endproperty
  a_seg1_e1: assert property (p_seg1_e1) else $error("seg1 E1 AIS missed");

  property p_parity;
    clk_rise |=> q_reg.par == $past(par_err);
  endproperty
  a_parity: assert property (p_parity) else $error("parity alarm wrong");

  property p_loc_set;
    !clk_edge && q_reg.loc_cnt == LOC_LAST |=> q_reg.loc;
  endproperty
  a_loc_set: assert property (p_loc_set) else $error("loss of clock late");

  property p_loc_clr;
    q_reg.loc && clk_edge |=> !q_reg.loc;
  endproperty
  a_loc_clr: assert property (p_loc_clr) else $error("loss of clock stuck");

  property p_v1sel;
    q_reg.cfg[`DBAM_CFG_V1SEL] |=> q_reg.oom == 3'h0 && q_reg.lom == 3'h0;
  endproperty
  a_v1sel: assert property (p_v1sel) else $error("multiframe alarm in V1 mode");

  property p_oom_set;
    !q_reg.cfg[`DBAM_CFG_V1SEL] && clk_rise && bh4 && bseg == 2'h1 && !q_reg.oom[0] &&
      bdata[1:0] != q_reg.mf_prev[0] + 2'h1 |=> q_reg.oom[0];
  endproperty
  a_oom_set: assert property (p_oom_set) else $error("OOM not declared");

  property p_oom_clr;
    !q_reg.cfg[`DBAM_CFG_V1SEL] && clk_rise && bh4 && bseg == 2'h1 && q_reg.oom[0] &&
      q_reg.mf_run[0] == MF_GOOD - 3'h1 && bdata[1:0] == q_reg.mf_prev[0] + 2'h1
      |=> !q_reg.oom[0] && !q_reg.lom[0];
  endproperty
  a_oom_clr: assert property (p_oom_clr) else $error("OOM not cleared");

  property p_lom_set;
    !q_reg.cfg[`DBAM_CFG_V1SEL] && q_reg.oom[0] && q_reg.lom_cnt[0] == LOM_LAST
      |=> q_reg.lom[0] || !q_reg.oom[0];
  endproperty
  a_lom_set: assert property (p_lom_set) else $error("LOM not declared");

  property p_lom_needs_oom;
    !q_reg.oom[0] |-> !q_reg.lom[0];
  endproperty
  a_lom_needs_oom: assert property (p_lom_needs_oom) else $error("LOM without OOM");

  property p_lop;
    chan_seg_i[1:0] == 2'h1 |=> channel_pointer_lost_o[0] == $past(q_reg.lom[0]);
  endproperty
  a_lop: assert property (p_lop) else $error("pointer loss not forced");

  property p_latch_rise;
    edge_mode == DBAM_EDGE_RISE && live_word[1] && !q_reg.live_prev[1] |=> q_reg.latched[1];
  endproperty
  a_latch_rise: assert property (p_latch_rise) else $error("rise not latched");

  property p_read_clear;
    rd_latch && trans == 5'h00
      |=> q_reg.latched == 5'h00 && rd_data_o[4:0] == $past(q_reg.latched);
  endproperty
  a_read_clear: assert property (p_read_clear) else $error("latched not cleared");

  property p_live_read;
    rd_stb_i && addr_i == `DBAM_ADDR_LIVE |=> rd_data_o == {3'h0, $past(live_word)};
  endproperty
  a_live_read: assert property (p_live_read) else $error("live status read wrong");

  c_loc: cover property (!q_reg.loc ##1 q_reg.loc);
  c_oom: cover property (!q_reg.oom[0] ##1 q_reg.oom[0]);
  c_lom: cover property (q_reg.lom[0] ##1 !q_reg.lom[0]);
  c_read_latched: cover property (rd_latch && q_reg.latched != 5'h00);

endmodule : dbam_monitor

// file: rtl/dbam_defines.svh
// Offsets, field positions, reset values and timing counts of the drop bus alarm monitor
`ifndef DBAM_DEFINES_SVH
`define DBAM_DEFINES_SVH

`define DBAM_ADDR_CFG        8'h1D
`define DBAM_ADDR_LIVE       8'h60
`define DBAM_ADDR_MF         8'h61
`define DBAM_ADDR_LATCH      8'h62

`define DBAM_CFG_PTR_EN      0
`define DBAM_CFG_E1_SEL      1
`define DBAM_CFG_VC4         2
`define DBAM_CFG_V1SEL       3
`define DBAM_CFG_EDGE_LO     4
`define DBAM_CFG_EDGE_HI     5
`define DBAM_CFG_ODD_PAR     6
`define DBAM_CFG_RESET       8'h11
`define DBAM_CFG_MASK        8'h7F

`define DBAM_AIS_BYTE        8'hFF
`define DBAM_LOC_CYCLES      56
`define DBAM_MF_GOOD_FRAMES  4
`define DBAM_LOM_TIME_NS     1000000
`define DBAM_CLK_PERIOD_NS   5

`endif

// file: rtl/dbam_pkg.sv
// Types shared by the drop bus alarm monitor
package dbam_pkg;

  typedef enum logic [1:0] {
    DBAM_EDGE_NONE = 2'h0,
    DBAM_EDGE_RISE = 2'h1,
    DBAM_EDGE_FALL = 2'h2,
    DBAM_EDGE_BOTH = 2'h3
  } dbam_edge_t;

  typedef logic [1:0] dbam_seg_t;

endpackage : dbam_pkg

// file: dv/dbam_framer_model.sv
// Upstream framer model that drives the drop bus pins
module dbam_framer_model (
  output logic       clk_o = 1'b0,
  output logic [7:0] data_o = 8'h00,
  output logic       par_o = 1'b0,
  output logic [1:0] seg_o = 2'h0,
  output logic [3:0] kind_o = 4'h0
);
  timeunit 1ns;
  timeprecision 100ps;
  // One byte per drop clock period; kind is {h1, h2, e1, h4}; clock stands low between bytes
  task automatic send(input logic [7:0] d, input logic perr, input logic [1:0] s,
                      input logic [3:0] k);
    data_o = d;
    par_o = ^d ^ perr;
    seg_o = s;
    kind_o = k;
    #80 clk_o = 1'b1;
    #80 clk_o = 1'b0;
    data_o = ~d;
    par_o = ~par_o;
    seg_o = 2'h0;
    kind_o = 4'h0;
  endtask : send
endmodule : dbam_framer_model

// file: dv/drop_bus_alarm_monitor_tb.sv
// Self-checking bench for the drop bus alarm monitor
`include "dbam_defines.svh"
module drop_bus_alarm_monitor_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import dbam_pkg::*;
  localparam int LOM = 200;
  logic        core_clk = 1'b0;
  logic        nrst     = 1'b0;
  logic [15:0] chan_seg = 16'h0000;
  logic [7:0]  addr     = 8'h00;
  logic [7:0]  wdata    = 8'h00;
  logic        wr       = 1'b0;
  logic        rd       = 1'b0;
  logic [7:0]  rdata;
  logic [7:0]  lost;
  logic        dclk;
  logic [7:0]  ddata;
  logic        dpar;
  logic [1:0]  dseg;
  logic [3:0]  dkind;
  logic [7:0]  b;
  logic        e;
  logic [1:0]  mode;
  int          fails    = 0;
  int          compares = 0;
  int unsigned seed;

  always #2.5 core_clk = ~core_clk;

  dbam_framer_model fr (.clk_o(dclk), .data_o(ddata), .par_o(dpar), .seg_o(dseg),
                        .kind_o(dkind));

  dbam_monitor #(.LOM_CYCLES(LOM)) uut (
    .core_clk_i(core_clk), .nrst_i(nrst), .drop_bus_clock_i(dclk), .drop_data_i(ddata),
    .drop_parity_i(dpar), .drop_seg_i(dseg), .drop_h1_i(dkind[3]), .drop_h2_i(dkind[2]),
    .drop_e1_i(dkind[1]), .drop_h4_i(dkind[0]), .chan_seg_i(chan_seg), .addr_i(addr),
    .wr_data_i(wdata), .wr_stb_i(wr), .rd_stb_i(rd), .rd_data_o(rdata),
    .channel_pointer_lost_o(lost));

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge core_clk);
    wr <= 1'b0;
  endtask : wr_reg

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] m, input logic [7:0] x);
    @(posedge core_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge core_clk);
    rd <= 1'b0;
    #1 check(rdata & m, x);
  endtask : rd_chk

  function automatic logic [7:0] lost_exp(input logic [15:0] cs, input logic [1:0] s);
    for (int c = 0; c < 8; c++) lost_exp[c] = (cs[2*c +: 2] == s);
  endfunction : lost_exp

  task automatic tally_and_finish;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : tally_and_finish

  initial begin
    #400000;
    fails++;
    tally_and_finish();
  end

  initial begin
    seed = $urandom(32'h60DE);
    repeat (12) @(posedge core_clk);
    nrst <= 1'b1;
    rd_chk(`DBAM_ADDR_CFG, 8'hFF, `DBAM_CFG_RESET);
    wr_reg(`DBAM_ADDR_LIVE, 8'hFF);
    rd_chk(`DBAM_ADDR_LIVE, 8'hE0, 8'h00);
    rd_chk(`DBAM_ADDR_MF, 8'hC0, 8'h00);
    rd_chk(8'h7F, 8'hFF, 8'h00);
    $display("test reset done");
    repeat (`DBAM_LOC_CYCLES + 10) @(posedge core_clk);
    rd_chk(`DBAM_ADDR_LIVE, 8'h01, 8'h01);
    rd_chk(`DBAM_ADDR_LATCH, 8'h01, 8'h01);
    rd_chk(`DBAM_ADDR_LATCH, 8'h01, 8'h00);
    fr.send(8'h00, 1'b0, 2'h0, 4'h0);
    rd_chk(`DBAM_ADDR_LIVE, 8'h01, 8'h00);
    $display("test loss of clock done");
    for (int i = 0; i < 8; i++) begin
      b = 8'($urandom);
      e = (i < 2) ? i[0] : 1'($urandom);
      fr.send(b, e, 2'h0, 4'h0);
      rd_chk(`DBAM_ADDR_LIVE, 8'h02, {6'h00, e, 1'b0});
    end
    wr_reg(`DBAM_ADDR_CFG, 8'h51);
    fr.send(8'($urandom), 1'b1, 2'h0, 4'h0);
    rd_chk(`DBAM_ADDR_LIVE, 8'h02, 8'h00);
    fr.send(8'($urandom), 1'b0, 2'h0, 4'h0);
    rd_chk(`DBAM_ADDR_LIVE, 8'h02, 8'h02);
    $display("test parity done");
    for (int i = 0; i < 4; i++) begin
      mode = 2'(i);
      wr_reg(`DBAM_ADDR_CFG, {2'b00, mode, 4'h1});
      fr.send(8'h3C, 1'b0, 2'h0, 4'h0);
      rd_chk(`DBAM_ADDR_LATCH, 8'h00, 8'h00);
      fr.send(8'h3C, 1'b1, 2'h0, 4'h0);
      rd_chk(`DBAM_ADDR_LATCH, 8'h02, {6'h00, mode[0], 1'b0});
      fr.send(8'h3C, 1'b0, 2'h0, 4'h0);
      rd_chk(`DBAM_ADDR_LATCH, 8'h02, {6'h00, mode[1], 1'b0});
    end
    $display("test latch edges done");
    wr_reg(`DBAM_ADDR_CFG, 8'h11);
    fr.send(8'hFF, 1'b0, 2'h3, 4'h8);
    fr.send(8'hFF, 1'b0, 2'h3, 4'h4);
    rd_chk(`DBAM_ADDR_LIVE, 8'h1C, 8'h10);
    fr.send(8'h00, 1'b0, 2'h3, 4'h8);
    fr.send(8'h00, 1'b0, 2'h3, 4'h4);
    rd_chk(`DBAM_ADDR_LIVE, 8'h1C, 8'h00);
    wr_reg(`DBAM_ADDR_CFG, 8'h12);
    for (int s = 1; s < 4; s++) begin
      fr.send(8'hFF, 1'b0, 2'(s), 4'h2);
      rd_chk(`DBAM_ADDR_LIVE, 8'h04 << s - 1, 8'h04 << s - 1);
    end
    wr_reg(`DBAM_ADDR_CFG, 8'h16);
    rd_chk(`DBAM_ADDR_LIVE, 8'h1C, 8'h04);
    $display("test upstream alarm done");
    wr_reg(`DBAM_ADDR_CFG, 8'h11);
    chan_seg <= 16'($urandom);
    for (int k = 0; k < 4; k++) fr.send({6'($urandom), 2'(k)}, 1'b0, 2'h1, 4'h1);
    rd_chk(`DBAM_ADDR_MF, 8'h09, 8'h00);
    fr.send(8'h01, 1'b0, 2'h1, 4'h1);
    rd_chk(`DBAM_ADDR_MF, 8'h09, 8'h08);
    repeat (LOM + 20) @(posedge core_clk);
    rd_chk(`DBAM_ADDR_MF, 8'h09, 8'h09);
    check(lost, lost_exp(chan_seg, 2'h1));
    for (int k = 0; k < 4; k++) fr.send({6'($urandom), 2'(k)}, 1'b0, 2'h1, 4'h1);
    rd_chk(`DBAM_ADDR_MF, 8'h09, 8'h00);
    check(lost, 8'h00);
    wr_reg(`DBAM_ADDR_CFG, 8'h19);
    fr.send(8'h02, 1'b0, 2'h1, 4'h1);
    rd_chk(`DBAM_ADDR_MF, 8'h3F, 8'h00);
    $display("test multiframe done");
    tally_and_finish();
  end
endmodule : drop_bus_alarm_monitor_tb
